//--- i2cs_chk.sv
// Checker for the two-wire control target, watching top ports only.
// Assumes the bus master toggles the clock line slowly (20 cycle halves).
`timescale 1ns/100ps
module i2cs_chk (
   input wire       clk_sys,
   input wire       rst_n,
   input wire       scl_in,
   input wire       sda_in,
   input wire       scl_out,
   input wire       scl_oe,
   input wire       sda_out,
   input wire       sda_oe,
   input wire       busy,
   input wire [7:0] page_sel
);
   // ****
   // Properties
   // ****
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Start and stop must outlast the line filter
   sequence s_start;
      $fell(sda_in) && scl_in ##1 (scl_in && !sda_in) [*4];
   endsequence
   sequence s_stop;
      $rose(sda_in) && scl_in ##1 (scl_in && sda_in) [*4];
   endsequence
   a_no_clk_drive: assert property (!scl_oe && !scl_out)
      else $error("clock line driven");
   a_low_only: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   a_rst_idle: assert property ($rose(rst_n) |->
      !busy && !sda_oe && page_sel == 8'h00)
      else $error("not idle after reset");
   a_start_busy: assert property (s_start |-> ##[1:8] busy)
      else $error("start not seen");
   a_stop_idle: assert property (s_stop |-> ##[1:8] !busy)
      else $error("stop not seen");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data changed with clock high");
   a_oe_in_busy: assert property (sda_oe |-> busy)
      else $error("data driven outside transfer");
   a_page_in_busy: assert property ($changed(page_sel) |-> busy)
      else $error("page changed outside transfer");
   c_ack: cover property ($rose(sda_oe));
   c_page: cover property ($changed(page_sel));
   c_stop: cover property ($fell(busy));
endmodule
bind i2cs_top i2cs_chk i2cs_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
   .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .page_sel(page_sel));

//--- i2cs_defines.vh
// Constants for the two-wire control target and its register store.
// Assumes inclusion by bare name from the design files.
`ifndef I2CS_DEFINES_VH
`define I2CS_DEFINES_VH
// ***********************************
// Bus address and general call
// ***********************************
`define I2CS_DEV_ADDR     7'h18
`define I2CS_GCALL_ADDR   7'h00
// ***********************************
// Register map
// ***********************************
`define I2CS_REG_PAGE     7'h00
`define I2CS_REG_GCALL    7'h22
`define I2CS_GCALL_BIT    5
`define I2CS_PAGE_RST     8'h00
`define I2CS_NUM_REGS     128
`define I2CS_NUM_PAGES    2
// ***********************************
// Line filter
// ***********************************
`define I2CS_FILT_LEN     3
`endif

//--- i2cs_filter.v
// Two-flop synchroniser plus stable-run glitch filter for one line.
// Assumes the line is asynchronous to clk_sys and idles high.
`timescale 1ns/100ps
`include "i2cs_defines.vh"
module i2cs_filter (
   clk_sys,
   rst_n,
   line_in,
   line_out
);
   input  wire clk_sys;
   input  wire rst_n;
   input  wire line_in;
   output wire line_out;

   reg       meta_ff;
   reg       sync_ff;
   reg [1:0] cnt_ff;
   reg       filt_ff;

   // ***********************************
   // Synchronise, then require a stable run
   // ***********************************
   // A new level is accepted only after it holds for the filter length
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         cnt_ff  <= 2'h0;
         filt_ff <= 1'b1;
      end else begin
         meta_ff <= line_in;
         sync_ff <= meta_ff;
         if (sync_ff == filt_ff) begin
            cnt_ff <= 2'h0;
         end else if (cnt_ff == (`I2CS_FILT_LEN - 1)) begin
            cnt_ff  <= 2'h0;
            filt_ff <= sync_ff;
         end else begin
            cnt_ff <= cnt_ff + 2'h1;
         end
      end
   end

   assign line_out = filt_ff;
endmodule

//--- i2cs_master.sv
// Bus master model: pulls clock and data low or releases them.
// Assumes the bench wire-ANDs these flags with the target's pull.
`timescale 1ns/100ps
module i2cs_master #(
   parameter HALF = 20
) (
   input  wire  clk_sys,
   input  wire  sda,
   output logic scl_low,
   output logic sda_low
);
   // ****
   // Bit and frame tasks
   // ****
   // Released lines rise through pull-ups only
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Long low phase leaves room for the target's filter delay
   task automatic bit_c(input logic b, output logic s);
      sda_low <= !b;
      w(HALF);
      scl_low <= 1'b0;
      w(HALF);
      s = sda;
      scl_low <= 1'b1;
      w(HALF);
   endtask
   task automatic start_c;
      sda_low <= 1'b0;
      w(HALF);
      scl_low <= 1'b0;
      w(HALF);
      sda_low <= 1'b1;
      w(HALF);
      scl_low <= 1'b1;
      w(HALF);
   endtask
   task automatic stop_c;
      sda_low <= 1'b1;
      w(HALF);
      scl_low <= 1'b0;
      w(HALF);
      sda_low <= 1'b0;
      w(HALF);
   endtask
   // One-cycle dip, too short to count as a start
   task automatic glitch;
      sda_low <= 1'b1;
      w(1);
      sda_low <= 1'b0;
      w(HALF);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_c(d[i], s);
      bit_c(1'b1, s);
      ack = !s;
   endtask
   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, s);
         d[i] = s;
      end
      bit_c(!mack, s);
   endtask
endmodule

//--- i2cs_top.v
// Two-wire control target with paged 8-bit register store.
// Assumes an external master, pull-ups on both lines and 100 MHz clk_sys.
`timescale 1ns/100ps
`include "i2cs_defines.vh"
module i2cs_top (
   clk_sys,
   rst_n,
   scl_in,
   sda_in,
   scl_out,
   scl_oe,
   sda_out,
   sda_oe,
   busy,
   page_sel
);
   input  wire       clk_sys;
   input  wire       rst_n;
   input  wire       scl_in;
   input  wire       sda_in;
   output wire       scl_out;
   output wire       scl_oe;
   output wire       sda_out;
   output reg        sda_oe;
   output reg        busy;
   output reg  [7:0] page_sel;

   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_AACK  = 3'h2;
   localparam ST_WR    = 3'h3;
   localparam ST_WACK  = 3'h4;
   localparam ST_RD    = 3'h5;
   localparam ST_RACK  = 3'h6;

   wire       scl_f;
   wire       sda_f;
   reg        scl_d_ff;
   reg        sda_d_ff;
   reg  [2:0] st_ff;
   reg  [3:0] bit_ff;
   reg  [7:0] shf_ff;
   reg  [6:0] ptr_ff;
   reg        ptr_set_ff;
   reg        ack_ok_ff;
   reg  [7:0] mem_ff [0:`I2CS_NUM_PAGES*`I2CS_NUM_REGS-1];
   reg  [7:0] rd_byte;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_c;
   wire       stop_c;
   wire       page_ok;
   wire [7:0] mem_idx;
   wire       gcall_en;
   wire       wr_strobe;

   // ***********************************
   // Line conditioning
   // ***********************************
   i2cs_filter u_scl_filt (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .line_in  (scl_in),
      .line_out (scl_f)
   );
   i2cs_filter u_sda_filt (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .line_in  (sda_in),
      .line_out (sda_f)
   );

   // Delayed filtered levels for edge detection
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_f;
         sda_d_ff <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_d_ff;
   assign scl_fall = ~scl_f & scl_d_ff;
   assign start_c  = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
   assign stop_c   = scl_f & scl_d_ff & ~sda_d_ff & sda_f;

   // Clock line is never driven; target only
   assign scl_out = 1'b0;
   assign scl_oe  = 1'b0;
   // Data line only ever pulled low
   assign sda_out = 1'b0;

   // ***********************************
   // Register store addressing
   // ***********************************
   // Only page 0 and 1 are backed; other pages read zero, ignore writes
   assign page_ok  = (page_sel < `I2CS_NUM_PAGES);
   assign mem_idx  = {page_sel[0], ptr_ff};
   assign gcall_en = mem_ff[`I2CS_REG_GCALL][`I2CS_GCALL_BIT];

   // Page register is common to all pages
   always @* begin
      if (ptr_ff == `I2CS_REG_PAGE) begin
         rd_byte = page_sel;
      end else if (page_ok) begin
         rd_byte = mem_ff[mem_idx];
      end else begin
         rd_byte = 8'h00;
      end
   end

   // Byte written when the clock falls after the eighth bit of a data byte
   assign wr_strobe = (st_ff == ST_WR) && scl_fall && (bit_ff == 4'h8)
                      && ptr_set_ff;

   // ***********************************
   // Register storage, one write port
   // ***********************************
   genvar gi;
   generate
      for (gi = 0; gi < `I2CS_NUM_PAGES*`I2CS_NUM_REGS; gi = gi + 1) begin : g_reg
         always @(posedge clk_sys) begin
            if (!rst_n) begin
               mem_ff[gi] <= 8'h00;
            end else if (wr_strobe && page_ok &&
                         (ptr_ff != `I2CS_REG_PAGE) &&
                         (mem_idx == gi)) begin
               mem_ff[gi] <= shf_ff;
            end
         end
      end
   endgenerate

   // ***********************************
   // Protocol engine
   // ***********************************
   // Bits sampled on clock rise, ack and data driven after clock fall
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         st_ff      <= ST_IDLE;
         bit_ff     <= 4'h0;
         shf_ff     <= 8'h00;
         ptr_ff     <= 7'h00;
         ptr_set_ff <= 1'b0;
         ack_ok_ff  <= 1'b0;
         sda_oe     <= 1'b0;
         busy       <= 1'b0;
         page_sel   <= `I2CS_PAGE_RST;
      end else if (start_c) begin
         // Repeated START restarts decoding, pointer kept
         st_ff      <= ST_ADDR;
         bit_ff     <= 4'h0;
         ptr_set_ff <= 1'b0;
         sda_oe     <= 1'b0;
         busy       <= 1'b1;
      end else if (stop_c) begin
         st_ff  <= ST_IDLE;
         sda_oe <= 1'b0;
         busy   <= 1'b0;
      end else begin
         case (st_ff)
            ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            ST_ADDR, ST_WR: begin
               if (scl_rise && bit_ff < 4'h8) begin
                  shf_ff <= {shf_ff[6:0], sda_f};
                  bit_ff <= bit_ff + 4'h1;
               end else if (scl_fall && bit_ff == 4'h8) begin
                  bit_ff <= 4'h0;
                  if (st_ff == ST_ADDR) begin
                     // Match own address, or general call if enabled
                     if (shf_ff[7:1] == `I2CS_DEV_ADDR ||
                         (shf_ff[7:1] == `I2CS_GCALL_ADDR &&
                          !shf_ff[0] && gcall_en)) begin
                        ack_ok_ff <= shf_ff[0];
                        sda_oe    <= 1'b1;
                        st_ff     <= ST_AACK;
                     end else begin
                        st_ff <= ST_IDLE;
                     end
                  end else begin
                     if (!ptr_set_ff) begin
                        ptr_ff     <= shf_ff[6:0];
                        ptr_set_ff <= 1'b1;
                     end else begin
                        if (ptr_ff == `I2CS_REG_PAGE) begin
                           page_sel <= shf_ff;
                        end
                        ptr_ff <= ptr_ff + 7'h01;
                     end
                     sda_oe <= 1'b1;
                     st_ff  <= ST_WACK;
                  end
               end
            end
            ST_AACK, ST_WACK: begin
               // Release after the acknowledge clock ends; an acked read address drives its first bit instead
               if (scl_fall) begin
                  if (st_ff == ST_AACK && ack_ok_ff) begin
                     sda_oe <= ~rd_byte[7];
                     shf_ff <= {rd_byte[6:0], 1'b1};
                     bit_ff <= 4'h1;
                     st_ff  <= ST_RD;
                  end else begin
                     sda_oe <= 1'b0;
                     st_ff  <= ST_WR;
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (bit_ff == 4'h8) begin
                     sda_oe <= 1'b0;
                     st_ff  <= ST_RACK;
                     ptr_ff <= ptr_ff + 7'h01;
                  end else begin
                     sda_oe <= ~shf_ff[7];
                     shf_ff <= {shf_ff[6:0], 1'b1};
                     bit_ff <= bit_ff + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  ack_ok_ff <= ~sda_f;
               end else if (scl_fall) begin
                  if (ack_ok_ff) begin
                     sda_oe <= ~rd_byte[7];
                     shf_ff <= {rd_byte[6:0], 1'b1};
                     bit_ff <= 4'h1;
                     st_ff  <= ST_RD;
                  end else begin
                     st_ff <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_ff  <= ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end
endmodule

//--- tb.sv
// Self-checking bench for the two-wire control target.
// Assumes the master model and bound checker are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   n_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   wire        scl_low, sda_low, scl_out, scl_oe, sda_out, sda_oe, busy;
   wire  [7:0] page_sel;
   wire        scl_line = !(scl_low | (scl_oe & !scl_out));
   wire        sda_line = !(sda_low | (sda_oe & !sda_out));
   int         n_errors = 0;
   int         checks_done = 0;
   i2cs_top i2cs_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy),
      .page_sel(page_sel));
   i2cs_master i2cs_master_inst (.clk_sys(clk_sys), .sda(sda_line),
      .scl_low(scl_low), .sda_low(sda_low));
   // ****
   // Transfer helpers
   // ****
   task automatic wb(input logic [7:0] d, input logic e);
      logic a;
      i2cs_master_inst.wr_byte(d, a);
      `CHK("ack", e, a)
   endtask
   task automatic rb(input logic m, input logic [7:0] e);
      logic [7:0] d;
      i2cs_master_inst.rd_byte(m, d);
      `CHK("rdata", e, d)
   endtask
   task automatic head(input logic [7:0] p);
      i2cs_master_inst.start_c();
      wb(8'h30, 1'b1);
      wb(p, 1'b1);
   endtask
   task automatic put(input logic [7:0] p, input logic [7:0] d);
      head(p);
      wb(d, 1'b1);
      i2cs_master_inst.stop_c();
   endtask
   task automatic get2(input logic [7:0] p, e0, e1);
      head(p);
      i2cs_master_inst.start_c();
      wb(8'h31, 1'b1);
      rb(1'b1, e0);
      rb(1'b0, e1);
      i2cs_master_inst.stop_c();
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_other;
      logic [7:0] al [3] = '{8'h32, 8'h20, 8'h70};
      foreach (al[i]) begin
         i2cs_master_inst.start_c();
         wb(al[i], 1'b0);
         wb(8'h00, 1'b0);
         i2cs_master_inst.stop_c();
         `CHK("busy", 1'b0, busy)
      end
      `CHK("page", 8'h00, page_sel)
      `CHK("scl_oe", 1'b0, scl_oe)
      `CHK("scl_out", 1'b0, scl_out)
      `CHK("sda_out", 1'b0, sda_out)
      `CHK("sda_oe", 1'b0, sda_oe)
      $display("t_other done");
   endtask
   task automatic t_autoinc;
      head(8'h05);
      `CHK("busy", 1'b1, busy)
      wb(8'ha5, 1'b1);
      wb(8'h3c, 1'b1);
      i2cs_master_inst.stop_c();
      get2(8'h05, 8'ha5, 8'h3c);
      $display("t_autoinc done");
   endtask
   task automatic t_gcall;
      i2cs_master_inst.start_c();
      wb(8'h00, 1'b0);
      i2cs_master_inst.stop_c();
      put(8'h22, 8'h20);
      i2cs_master_inst.start_c();
      wb(8'h00, 1'b1);
      i2cs_master_inst.stop_c();
      $display("t_gcall done");
   endtask
   task automatic t_page;
      put(8'h00, 8'h01);
      `CHK("page", 8'h01, page_sel)
      put(8'h05, 8'h77);
      get2(8'h05, 8'h77, 8'h00);
      put(8'h00, 8'h00);
      get2(8'h05, 8'ha5, 8'h3c);
      head(8'h7f);
      wb(8'h11, 1'b1);
      wb(8'h22, 1'b1);
      i2cs_master_inst.stop_c();
      `CHK("page", 8'h22, page_sel)
      put(8'h00, 8'h00);
      $display("t_page done");
   endtask
   task automatic t_glitch;
      i2cs_master_inst.glitch();
      `CHK("busy", 1'b0, busy)
      $display("t_glitch done");
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ****
   // Clock, sequence and watchdog
   // ****
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      `CHK("page", 8'h00, page_sel)
      t_other();
      t_autoinc();
      t_gcall();
      t_page();
      t_glitch();
      finish_test();
   end
   // Hang guard well beyond the longest run
   initial begin
      repeat (100000) @(posedge clk_sys);
      n_errors++;
      finish_test();
   end
endmodule
